// [crfs_regs.svh]
// Constants for the core register file and stack block.
`ifndef CRFS_REGS_SVH
`define CRFS_REGS_SVH
`define CRFS_NUM_REGS 32
`define CRFS_REG_AW 5
`define CRFS_PTR_X_LO 5'h1a
`define CRFS_PTR_Y_LO 5'h1c
`define CRFS_PTR_Z_LO 5'h1e
`define CRFS_IO_BASE 16'h0020
`define CRFS_IO_LAST 16'h005f
`define CRFS_IO_SP_LO 6'h3d
`define CRFS_IO_SP_HI 6'h3e
`define CRFS_IO_FLAGS 6'h3f
`define CRFS_SP_W 9
`define CRFS_SP_RESET 9'h1_ff
`define CRFS_FLAG_I 7
`define CRFS_FLAG_T 6
`define CRFS_FLAG_H 5
`define CRFS_FLAG_S 4
`define CRFS_FLAG_V 3
`define CRFS_FLAG_N 2
`define CRFS_FLAG_Z 1
`define CRFS_FLAG_C 0
`define CRFS_NUM_IRQ 8
`define CRFS_VEC_W 4
`endif

// [crfs_pkg.sv]
// Types shared by the core register file and stack block.
package crfs_pkg;
    typedef enum logic [4:0] {
        CRFS_OP_NONE = 5'h00,
        CRFS_OP_PUSH = 5'h01,
        CRFS_OP_POP = 5'h02,
        CRFS_OP_CALL = 5'h03,
        CRFS_OP_RET = 5'h04,
        CRFS_OP_INTERRUPT_RETURN = 5'h05,
        CRFS_OP_ALU = 5'h06,
        CRFS_OP_MOVW = 5'h07,
        CRFS_OP_LDPTR = 5'h08,
        CRFS_OP_STPTR = 5'h09,
        CRFS_OP_LPM = 5'h0a,
        CRFS_OP_IN = 5'h0b,
        CRFS_OP_OUT = 5'h0c,
        CRFS_OP_SETI = 5'h0d,
        CRFS_OP_CLRI = 5'h0e
    } crfs_op_t;
    typedef enum logic [1:0] {
        CRFS_PM_DISP = 2'h0,
        CRFS_PM_INC = 2'h1,
        CRFS_PM_DEC = 2'h2
    } crfs_ptr_mode_t;
    typedef enum logic [1:0] {
        CRFS_PTR_X = 2'h0,
        CRFS_PTR_Y = 2'h1,
        CRFS_PTR_Z = 2'h2
    } crfs_ptr_sel_t;
    typedef enum logic [3:0] {
        CRFS_ST_RUN = 4'b0001,
        CRFS_ST_PUSH_HI = 4'b0010,
        CRFS_ST_POP_HI = 4'b0100,
        CRFS_ST_POP_LO = 4'b1000
    } crfs_state_t;
endpackage : crfs_pkg

// [crfs_regfile.sv]
// Thirty-two byte working register file with byte and word ports.
`timescale 1ns/1ps
`include "crfs_regs.svh"
module crfs_regfile (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] rd_a_addr,
    output logic [7:0] rd_a_data,
    input wire logic [4:0] rd_b_addr,
    output logic [7:0] rd_b_data,
    input wire logic [4:0] rd_w_addr,
    output logic [15:0] rd_w_data,
    input wire logic wr_en,
    input wire logic wr_wide,
    input wire logic [4:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic ptr_wr_en,
    input wire logic [1:0] ptr_wr_sel,
    input wire logic [15:0] ptr_wr_data,
    output logic [15:0] ptr_x,
    output logic [15:0] ptr_y,
    output logic [15:0] ptr_z
);
    import crfs_pkg::*;
    logic [7:0] mem [0:`CRFS_NUM_REGS-1];
    // Word ports use an even register; its odd neighbour is the high byte.
    assign rd_a_data = mem[rd_a_addr];
    assign rd_b_data = mem[rd_b_addr];
    assign rd_w_data = {mem[{rd_w_addr[4:1], 1'b1}], mem[{rd_w_addr[4:1], 1'b0}]};
    assign ptr_x = {mem[`CRFS_PTR_X_LO + 5'h01], mem[`CRFS_PTR_X_LO]};
    assign ptr_y = {mem[`CRFS_PTR_Y_LO + 5'h01], mem[`CRFS_PTR_Y_LO]};
    assign ptr_z = {mem[`CRFS_PTR_Z_LO + 5'h01], mem[`CRFS_PTR_Z_LO]};
    logic [4:0] ptr_lo;
    always_comb begin
        unique case (ptr_wr_sel)
            2'h0: ptr_lo = `CRFS_PTR_X_LO;
            2'h1: ptr_lo = `CRFS_PTR_Y_LO;
            default: ptr_lo = `CRFS_PTR_Z_LO;
        endcase
    end
    genvar gi;
    generate
        for (gi = 0; gi < `CRFS_NUM_REGS; gi++) begin : g_reg
            localparam logic [4:0] IDX = 5'(gi);
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    mem[gi] <= 8'h00;
                end else if (wr_en && wr_addr == IDX) begin
                    mem[gi] <= wr_data[7:0];
                end else if (wr_en && wr_wide && {wr_addr[4:1], 1'b1} == IDX) begin
                    mem[gi] <= wr_data[15:8];
                end else if (ptr_wr_en && ptr_lo == IDX) begin
                    mem[gi] <= ptr_wr_data[7:0];
                end else if (ptr_wr_en && ptr_lo + 5'h01 == IDX) begin
                    mem[gi] <= ptr_wr_data[15:8];
                end
            end
        end
    endgenerate
endmodule : crfs_regfile

// [crfs_irq_arb.sv]
// Fixed-priority interrupt picker: lowest vector wins.
`timescale 1ns/1ps
`include "crfs_regs.svh"
module crfs_irq_arb (
    input wire logic [`CRFS_NUM_IRQ-1:0] irq_req,
    input wire logic global_en,
    output logic take,
    output logic [`CRFS_VEC_W-1:0] vector
);
    import crfs_pkg::*;
    always_comb begin
        take = 1'b0;
        vector = '0;
        // Scanning downward leaves the lowest index last, so it wins.
        for (int i = `CRFS_NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_req[i] && global_en) begin
                take = 1'b1;
                vector = `CRFS_VEC_W'(i + 1);
            end
        end
    end
endmodule : crfs_irq_arb

// [crfs_core.sv]
// Core datapath frame: fetch overlap, register file, pointers, stack and flags.
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Next instruction word is fetched while the current one executes.
// - Thirty-two byte registers, each read and written in one cycle.
// - Two-operand ALU op reads, computes and writes back in one cycle.
// - Ports: 8r+8w, two 8r+8w, two 8r+16w, 16r+16w.
// - Top six registers form three 16-bit data pointers.
// - One pointer also addresses constant tables in program flash.
// - Pointer access offers displacement, post-increment and pre-decrement.
// - Data addresses 0 to 31 go out to data memory; the working registers are not mapped there.
// - Sixty-four I/O addresses, also at data addresses 0x20 to 0x5F.
// - Instructions are one 16-bit word, some take two words.
// - Flags register updates after every ALU operation.
// - Interrupt entry and return never save or restore the flags.
// - Call or interrupt entry stores the return counter on the stack.
// - Stack grows downward; stack pointer marks the top.
// - Byte push decrements stack pointer by one, pop increments by one.
// - Call or interrupt push minus two; both returns plus two.
// - Stack pointer lives as low and high byte I/O registers.
// - Each interrupt has a vector; lower vector has priority.
// - Interrupt controls in I/O space; global enable flag gates all.
// - Taking an interrupt clears global enable; interrupt return sets it.
// - Core runs straight on the chip clock, undivided.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "crfs_regs.svh"
module crfs_core (
    input wire logic clk,
    input wire logic nrst,
    input wire crfs_pkg::crfs_op_t op,
    input wire logic op_second_word,
    input wire logic [4:0] dst_addr,
    input wire logic [4:0] src_addr,
    input wire logic [15:0] alu_result,
    input wire logic alu_wide,
    input wire logic [7:0] alu_flags,
    input wire logic [7:0] alu_flag_mask,
    input wire crfs_pkg::crfs_ptr_sel_t ptr_sel,
    input wire crfs_pkg::crfs_ptr_mode_t ptr_mode,
    input wire logic [5:0] ptr_disp,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic [15:0] prog_rdata,
    input wire logic [15:0] branch_target,
    input wire logic branch_take,
    input wire logic [`CRFS_NUM_IRQ-1:0] irq_req,
    output logic [15:0] instr_fetch_counter,
    output logic [15:0] instr_word,
    output logic [15:0] data_addr,
    output logic [7:0] data_wdata,
    output logic data_we,
    output logic data_re,
    output logic io_sel,
    output logic [15:0] prog_addr,
    output logic [7:0] operand_a,
    output logic [7:0] operand_b,
    output logic [15:0] operand_w,
    output logic [7:0] flags_register,
    output logic [7:0] stack_ptr_lower,
    output logic [7:0] stack_ptr_upper,
    output logic irq_ack,
    output logic [`CRFS_VEC_W-1:0] irq_vector,
    output logic busy
);
    import crfs_pkg::*;
    //////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        crfs_state_t state;
        logic [15:0] pc;
        logic [15:0] ir;
        logic [`CRFS_SP_W-1:0] sp;
        logic [7:0] flags;
        logic [15:0] ret_addr;
        logic [15:0] daddr;
        logic [7:0] dwdata;
        logic dwe;
        logic dre;
        logic iosel;
        logic [15:0] paddr;
        logic ack;
        logic [`CRFS_VEC_W-1:0] vec;
        logic busy;
        logic [7:0] ret_hi;
        logic [1:0] pop_wb;
        logic [4:0] pop_dst;
    } crfs_core_state_t;
    crfs_core_state_t cur;
    crfs_core_state_t next_cur;
    logic [7:0] rf_a;
    logic [7:0] rf_b;
    logic [15:0] rf_w;
    logic [15:0] ptr_x;
    logic [15:0] ptr_y;
    logic [15:0] ptr_z;
    logic rf_we;
    logic rf_wide;
    logic [4:0] rf_waddr;
    logic [15:0] rf_wdata;
    logic ptr_we;
    logic [15:0] ptr_new;
    logic irq_take;
    logic [`CRFS_VEC_W-1:0] irq_vec;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_eff;
    logic [15:0] sp_word;
    crfs_regfile u_regfile (
        .clk(clk),
        .nrst(nrst),
        .rd_a_addr(dst_addr),
        .rd_a_data(rf_a),
        .rd_b_addr(src_addr),
        .rd_b_data(rf_b),
        .rd_w_addr(src_addr),
        .rd_w_data(rf_w),
        .wr_en(rf_we),
        .wr_wide(rf_wide),
        .wr_addr(rf_waddr),
        .wr_data(rf_wdata),
        .ptr_wr_en(ptr_we),
        .ptr_wr_sel(ptr_sel),
        .ptr_wr_data(ptr_new),
        .ptr_x(ptr_x),
        .ptr_y(ptr_y),
        .ptr_z(ptr_z)
    );
    crfs_irq_arb u_irq (
        .irq_req(irq_req),
        .global_en(cur.flags[`CRFS_FLAG_I]),
        .take(irq_take),
        .vector(irq_vec)
    );
    assign sp_word = {{(16 - `CRFS_SP_W){1'b0}}, cur.sp};
    //////////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (ptr_sel)
            CRFS_PTR_X: ptr_cur = ptr_x;
            CRFS_PTR_Y: ptr_cur = ptr_y;
            default: ptr_cur = ptr_z;
        endcase
        // Decrement is applied before the access, increment after it.
        unique case (ptr_mode)
            CRFS_PM_DISP: ptr_eff = ptr_cur + {10'h000, ptr_disp};
            CRFS_PM_DEC: ptr_eff = ptr_cur - 16'h0001;
            default: ptr_eff = ptr_cur;
        endcase
        unique case (ptr_mode)
            CRFS_PM_INC: ptr_new = ptr_cur + 16'h0001;
            CRFS_PM_DEC: ptr_new = ptr_cur - 16'h0001;
            default: ptr_new = ptr_cur;
        endcase
    end
    //////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_cur = cur;
        next_cur.dwe = 1'b0;
        next_cur.dre = 1'b0;
        next_cur.iosel = 1'b0;
        next_cur.ack = 1'b0;
        next_cur.pop_wb = {cur.pop_wb[0], 1'b0};
        rf_we = 1'b0;
        rf_wide = 1'b0;
        rf_waddr = dst_addr;
        rf_wdata = alu_result;
        ptr_we = 1'b0;
        unique case (cur.state)
            CRFS_ST_RUN: begin
                // Fetch of the next word overlaps this execute cycle.
                next_cur.ir = prog_rdata;
                next_cur.pc = cur.pc + 16'h0001;
                next_cur.busy = 1'b0;
                if (irq_take && op == CRFS_OP_NONE) begin
                    // Flags are not stacked here; handlers preserve them themselves.
                    next_cur.flags[`CRFS_FLAG_I] = 1'b0;
                    next_cur.ack = 1'b1;
                    next_cur.vec = irq_vec;
                    next_cur.ret_addr = cur.pc;
                    next_cur.pc = {12'h000, irq_vec};
                    next_cur.daddr = sp_word;
                    next_cur.dwdata = cur.pc[7:0];
                    next_cur.dwe = 1'b1;
                    next_cur.sp = cur.sp - `CRFS_SP_W'(1);
                    next_cur.state = CRFS_ST_PUSH_HI;
                    next_cur.busy = 1'b1;
                end else begin
                    unique case (op)
                        CRFS_OP_ALU: begin
                            rf_we = 1'b1;
                            rf_wide = alu_wide;
                            next_cur.flags = (cur.flags & ~alu_flag_mask) | (alu_flags & alu_flag_mask);
                        end
                        CRFS_OP_MOVW: begin
                            rf_we = 1'b1;
                            rf_wide = 1'b1;
                            rf_waddr = {dst_addr[4:1], 1'b0};
                            rf_wdata = rf_w;
                        end
                        CRFS_OP_PUSH: begin
                            next_cur.daddr = sp_word;
                            next_cur.dwdata = rf_a;
                            next_cur.dwe = 1'b1;
                            next_cur.sp = cur.sp - `CRFS_SP_W'(1);
                        end
                        CRFS_OP_POP: begin
                            next_cur.sp = cur.sp + `CRFS_SP_W'(1);
                            next_cur.pop_wb[0] = 1'b1;
                            next_cur.pop_dst = dst_addr;
                            next_cur.daddr = sp_word + 16'h0001;
                            next_cur.dre = 1'b1;
                        end
                        CRFS_OP_LDPTR: begin
                            ptr_we = 1'b1;
                            next_cur.daddr = ptr_eff;
                            next_cur.dre = 1'b1;
                        end
                        CRFS_OP_STPTR: begin
                            ptr_we = 1'b1;
                            next_cur.daddr = ptr_eff;
                            next_cur.dwdata = rf_a;
                            next_cur.dwe = 1'b1;
                        end
                        CRFS_OP_LPM: begin
                            ptr_we = (ptr_mode == CRFS_PM_INC);
                        end
                        CRFS_OP_IN: begin
                            if (io_addr == `CRFS_IO_SP_LO) begin
                                rf_we = 1'b1;
                                rf_wdata = {8'h00, sp_word[7:0]};
                            end else if (io_addr == `CRFS_IO_SP_HI) begin
                                rf_we = 1'b1;
                                rf_wdata = {8'h00, sp_word[15:8]};
                            end else if (io_addr == `CRFS_IO_FLAGS) begin
                                rf_we = 1'b1;
                                rf_wdata = {8'h00, cur.flags};
                            end else begin
                                next_cur.daddr = `CRFS_IO_BASE + {10'h000, io_addr};
                                next_cur.dre = 1'b1;
                                next_cur.iosel = 1'b1;
                            end
                        end
                        CRFS_OP_OUT: begin
                            if (io_addr == `CRFS_IO_SP_LO) begin
                                next_cur.sp[7:0] = rf_a;
                            end else if (io_addr == `CRFS_IO_SP_HI) begin
                                next_cur.sp[`CRFS_SP_W-1:8] = rf_a[`CRFS_SP_W-9:0];
                            end else if (io_addr == `CRFS_IO_FLAGS) begin
                                next_cur.flags = rf_a;
                            end else begin
                                next_cur.daddr = `CRFS_IO_BASE + {10'h000, io_addr};
                                next_cur.dwdata = rf_a;
                                next_cur.dwe = 1'b1;
                                next_cur.iosel = 1'b1;
                            end
                        end
                        CRFS_OP_SETI: next_cur.flags[`CRFS_FLAG_I] = 1'b1;
                        CRFS_OP_CLRI: next_cur.flags[`CRFS_FLAG_I] = 1'b0;
                        CRFS_OP_CALL: begin
                            next_cur.ret_addr = cur.pc + {15'h0000, op_second_word};
                            next_cur.pc = branch_target;
                            next_cur.daddr = sp_word;
                            next_cur.dwdata = (cur.pc[7:0] + {7'h00, op_second_word});
                            next_cur.dwe = 1'b1;
                            next_cur.sp = cur.sp - `CRFS_SP_W'(1);
                            next_cur.state = CRFS_ST_PUSH_HI;
                            next_cur.busy = 1'b1;
                        end
                        CRFS_OP_RET, CRFS_OP_INTERRUPT_RETURN: begin
                            next_cur.sp = cur.sp + `CRFS_SP_W'(1);
                            next_cur.daddr = sp_word + 16'h0001;
                            next_cur.dre = 1'b1;
                            next_cur.state = CRFS_ST_POP_HI;
                            next_cur.busy = 1'b1;
                            if (op == CRFS_OP_INTERRUPT_RETURN) begin
                                next_cur.flags[`CRFS_FLAG_I] = 1'b1;
                            end
                        end
                        default: begin
                            if (branch_take) begin
                                next_cur.pc = branch_target;
                            end
                        end
                    endcase
                    if (op_second_word) begin
                        next_cur.pc = cur.pc + 16'h0002;
                    end
                    if (op == CRFS_OP_CALL) begin
                        next_cur.pc = branch_target;
                    end
                end
            end
            CRFS_ST_PUSH_HI: begin
                // Second byte lands on the same edge that loads the target's first word into the instruction register.
                next_cur.daddr = sp_word;
                next_cur.dwdata = cur.ret_addr[15:8];
                next_cur.dwe = 1'b1;
                next_cur.sp = cur.sp - `CRFS_SP_W'(1);
                next_cur.state = CRFS_ST_RUN;
            end
            CRFS_ST_POP_HI: begin
                next_cur.sp = cur.sp + `CRFS_SP_W'(1);
                next_cur.daddr = sp_word + 16'h0001;
                next_cur.dre = 1'b1;
                next_cur.state = CRFS_ST_POP_LO;
            end
            CRFS_ST_POP_LO: begin
                // Read data trails its strobe by one cycle, so the high byte arrives first.
                if (cur.dre) begin
                    next_cur.ret_hi = mem_rdata;
                end else begin
                    next_cur.pc = {cur.ret_hi, mem_rdata};
                    next_cur.state = CRFS_ST_RUN;
                end
            end
        endcase
        if (cur.pop_wb[1]) begin
            rf_we = 1'b1;
            rf_wide = 1'b0;
            rf_waddr = cur.pop_dst;
            rf_wdata = {8'h00, mem_rdata};
        end
        next_cur.paddr = (op == CRFS_OP_LPM && cur.state == CRFS_ST_RUN) ? ptr_z : next_cur.pc;
    end
    //////////////////////////////////////////////////////////////////////////////
    // The core uses clk directly; no divider sits in front of it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
            cur.state <= CRFS_ST_RUN;
            cur.sp <= `CRFS_SP_RESET;
        end else begin
            cur <= next_cur;
        end
    end
    assign instr_fetch_counter = cur.pc;
    assign instr_word = cur.ir;
    assign data_addr = cur.daddr;
    assign data_wdata = cur.dwdata;
    assign data_we = cur.dwe;
    assign data_re = cur.dre;
    assign io_sel = cur.iosel;
    assign prog_addr = cur.paddr;
    assign flags_register = cur.flags;
    assign stack_ptr_lower = cur.sp[7:0];
    assign stack_ptr_upper = sp_word[15:8];
    assign irq_ack = cur.ack;
    assign irq_vector = cur.vec;
    assign busy = cur.busy;
    assign operand_a = rf_a;
    assign operand_b = rf_b;
    assign operand_w = rf_w;
endmodule : crfs_core

// [crfs_core_checker.sv]
// Concurrent checks on the ports of the core register file and stack block.
`timescale 1ns/1ps
`include "crfs_regs.svh"
module crfs_core_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire crfs_pkg::crfs_op_t op,
    input wire logic busy,
    input wire logic alu_wide,
    input wire logic [4:0] dst_addr,
    input wire logic [15:0] alu_result,
    input wire logic [7:0] alu_flags,
    input wire logic [7:0] alu_flag_mask,
    input wire logic [`CRFS_NUM_IRQ-1:0] irq_req,
    input wire logic [7:0] operand_a,
    input wire logic [7:0] flags_register,
    input wire logic [7:0] stack_ptr_lower,
    input wire logic [7:0] stack_ptr_upper,
    input wire logic irq_ack,
    input wire logic [`CRFS_VEC_W-1:0] irq_vector
);
    import crfs_pkg::*;
    logic [15:0] sp;
    logic [7:0] res_lo;
    logic go;
    assign sp = {stack_ptr_upper, stack_ptr_lower};
    assign res_lo = alu_result[7:0];
    assign go = !busy;
    function automatic logic [3:0] first_vec(input logic [7:0] r);
        first_vec = 4'h0;
        for (int k = 7; k >= 0; k--) if (r[k]) first_vec = 4'(k + 1);
    endfunction : first_vec
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    push_step_a: assert property (op == CRFS_OP_PUSH && go |=> sp == $past(sp) - 16'h0001)
        else $error("push step");
    pop_step_a: assert property (op == CRFS_OP_POP && go |=> sp == $past(sp) + 16'h0001)
        else $error("pop step");
    call_push_a: assert property (op == CRFS_OP_CALL && go |-> ##3 sp == $past(sp, 3) - 16'h0002)
        else $error("call step");
    ret_pop_a: assert property ((op == CRFS_OP_RET || op == CRFS_OP_INTERRUPT_RETURN) && go |-> ##4 sp == $past(sp, 4) + 16'h0002)
        else $error("return step");
    interrupt_return_enable_a: assert property (op == CRFS_OP_INTERRUPT_RETURN && go |-> ##[1:4] flags_register[`CRFS_FLAG_I])
        else $error("return enable");
    irq_clear_a: assert property (irq_ack |=> !flags_register[`CRFS_FLAG_I])
        else $error("enable kept");
    irq_gate_a: assert property (irq_ack |-> $past(flags_register[`CRFS_FLAG_I]))
        else $error("gate open");
    irq_prio_a: assert property (irq_ack |-> irq_vector == first_vec($past(irq_req)))
        else $error("priority");
    flags_upd_a: assert property (op == CRFS_OP_ALU && go |=>
        (flags_register & $past(alu_flag_mask)) == ($past(alu_flags) & $past(alu_flag_mask)))
        else $error("flags update");
    alu_wb_a: assert property ((op == CRFS_OP_ALU && go && !alu_wide) ##1 $stable(dst_addr) |-> operand_a == $past(res_lo))
        else $error("write back");
    sp_width_a: assert property (stack_ptr_upper[7:1] == 7'h00)
        else $error("pointer width");
    cover property (irq_ack);
    cover property (op == CRFS_OP_CALL && go);
    cover property (op == CRFS_OP_INTERRUPT_RETURN && go);
endmodule : crfs_core_checker
bind crfs_core crfs_core_checker chk (.*);

// [crfs_mem_model.sv]
// Behavioural program flash and data memory facing the core.
`timescale 1ns/1ps
module crfs_mem_model (
    input wire logic clk,
    input wire logic [15:0] prog_addr,
    output logic [15:0] prog_rdata,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    input wire logic data_we,
    input wire logic data_re,
    input wire logic io_sel,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [0:511];
    assign prog_rdata = {prog_addr[7:0] ^ 8'h5a, ~prog_addr[15:8]};
    initial mem_rdata = 8'h00;
    always @(posedge clk) begin
        if (data_we === 1'b1 && io_sel !== 1'b1) begin
            ram[data_addr[8:0]] <= data_wdata;
        end
        // Outside a read the byte toggles, so stale data never passes for fresh.
        mem_rdata <= (data_re === 1'b1) ? ram[data_addr[8:0]] : ~mem_rdata;
    end
endmodule : crfs_mem_model

// [cpu_core_regfile_stack_test.sv]
// Self-checking bench for the core register file and stack block.
`timescale 1ns/1ps
`include "crfs_regs.svh"
module cpu_core_regfile_stack_test;
    import crfs_pkg::*;
    typedef struct {int sel; logic [15:0] v;} crfs_note_t;
    logic clk = 1'b0, nrst = 1'b0, op_second_word = 1'b0, alu_wide = 1'b0, branch_take = 1'b0;
    crfs_op_t op = CRFS_OP_NONE;
    crfs_ptr_sel_t ptr_sel = CRFS_PTR_X;
    crfs_ptr_mode_t ptr_mode = CRFS_PM_DISP;
    logic [4:0] dst_addr = 5'h00, src_addr = 5'h00;
    logic [5:0] ptr_disp = 6'h00, io_addr = 6'h00;
    logic [7:0] alu_flags = 8'h00, alu_flag_mask = 8'h00, irq_req = 8'h00, fl = 8'h00;
    logic [15:0] alu_result = 16'h0000, branch_target = 16'h0000, sp = 16'h01ff;
    logic [15:0] prog_rdata, instr_fetch_counter, instr_word, data_addr, prog_addr, operand_w;
    logic [7:0] mem_rdata, data_wdata, operand_a, operand_b, flags_register, stack_ptr_lower, stack_ptr_upper;
    logic data_we, data_re, io_sel, irq_ack, busy;
    logic [3:0] irq_vector;
    int err_count = 0;
    int comparisons = 0;
    crfs_note_t notes[$];
    logic [3:0] acks[$];
    crfs_core dut (.*);
    crfs_mem_model mem (.*);
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic note(input int s, input logic [15:0] v);
        notes.push_back('{s, v});
    endtask : note
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Ops stand one edge; stack sequences are waited out under a bound.
    task automatic run(input crfs_op_t o);
        int n;
        op <= o;
        @(posedge clk);
        op <= CRFS_OP_NONE;
        repeat (4) @(negedge clk);
        n = 0;
        while (busy !== 1'b0 && n < 16) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        if (n == 16) begin
            err_count++;
            tally_and_finish();
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        crfs_note_t n;
        if (irq_ack === 1'b1) begin
            n.v = (acks.size() > 0) ? {12'h000, acks.pop_front()} : 16'hffff;
            check("irq_vector", {12'h000, irq_vector}, n.v);
        end
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.sel)
                0: check("stack_ptr", {stack_ptr_upper, stack_ptr_lower}, n.v);
                1: check("flags", {8'h00, flags_register}, n.v);
                2: check("operand_a", {8'h00, operand_a}, n.v);
                5: check("operand_w", operand_w, n.v);
                default: check("acks_left", 16'(acks.size()), n.v);
            endcase
        end
    end
    initial begin
        logic [31:0] r;
        logic [4:0] d;
        logic [7:0] q;
        logic [3:0] vec;
        void'($urandom(3109));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // The reset pointer already lies above 0x60, so calls may follow at once.
        note(0, sp);
        note(1, {8'h00, fl});
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            d = 5'(2 * $urandom_range(14));
            dst_addr <= d;
            src_addr <= d;
            alu_result <= r[15:0];
            alu_wide <= r[16];
            alu_flags <= r[31:24];
            alu_flag_mask <= {1'b0, r[22:16]};
            ptr_sel <= crfs_ptr_sel_t'(2'(i % 3));
            ptr_mode <= crfs_ptr_mode_t'(2'(i % 3));
            ptr_disp <= r[5:0];
            io_addr <= r[29:24];
            branch_target <= r[31:16];
            run(CRFS_OP_ALU);
            fl = (fl & ~{1'b0, r[22:16]}) | (r[31:24] & {1'b0, r[22:16]});
            note(1, {8'h00, fl});
            note(r[16] ? 5 : 2, r[16] ? r[15:0] : {8'h00, r[7:0]});
            run(CRFS_OP_PUSH);
            sp -= 16'h0001;
            note(0, sp);
            dst_addr <= d + 5'h01;
            src_addr <= d + 5'h01;
            run(CRFS_OP_POP);
            sp += 16'h0001;
            note(0, sp);
            note(2, {8'h00, r[7:0]});
            run(CRFS_OP_CALL);
            note(0, sp - 16'h0002);
            run(CRFS_OP_RET);
            note(0, sp);
            q = (r[31:24] == 8'h00) ? 8'h40 : r[31:24];
            vec = 4'h0;
            for (int k = 7; k >= 0; k--) if (q[k]) vec = 4'(k + 1);
            acks.push_back(vec);
            irq_req <= q;
            run(CRFS_OP_SETI);
            irq_req <= 8'h00;
            note(0, sp - 16'h0002);
            note(1, {8'h00, fl});
            note(6, 16'h0000);
            run(CRFS_OP_INTERRUPT_RETURN);
            note(0, sp);
            note(1, {8'h00, fl | 8'h80});
            run(CRFS_OP_CLRI);
            note(1, {8'h00, fl});
        end
        run(CRFS_OP_NONE);
        tally_and_finish();
    end
endmodule : cpu_core_regfile_stack_test
